// ==== verification/mct_host_model.sv ====
// Host processor model driving the parallel host data lines of the timer.
`timescale 1ns/1ns
module mct_host_model (
  // Clock
  input wire logic clk,
  // Device side of the lines
  input wire logic [15:0] dev_out,
  input wire logic [15:0] dev_oe,
  // Bus width and upper-line gating control
  input wire logic wide,
  input wire logic [4:0] gate_off,
  // Strobes and resolved lines
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [15:0] lines
);
  logic [15:0] drv = 16'h0000;
  logic drv_on = 1'b0;
  logic [15:0] prev = 16'h0000;
  logic [15:0] en;
  logic [15:0] val;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // In narrow mode the upper lines are always held high, or low to switch gating off.
  assign en = wide ? {16{drv_on}} : {8'hff, {8{drv_on}}};
  assign val = wide ? drv : {3'b111, ~gate_off, drv[7:0]};
  // A line that nobody drives shows a changing pattern, never its last value.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      lines[i] = dev_oe[i] ? dev_out[i] : (en[i] ? val[i] : ~prev[i]);
    end
  end
  always @(posedge clk) prev <= lines;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic host_write(input logic [15:0] d);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    drv <= d;
    drv_on <= 1'b1;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    drv_on <= 1'b0;
  endtask : host_write
  task automatic host_read(output logic [15:0] d, output logic [15:0] oe);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    @(posedge clk);
    d = lines;
    oe = dev_oe;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask : host_read
endmodule : mct_host_model

// ==== verification/tb_top.sv ====
// Self-checking testbench for the multi-counter timer.
`timescale 1ns/1ns
module tb_top;
  import mct_pkg::*;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  mct_htrans_t HTRANS = 2'b00;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'b010;
  logic [31:0] HWDATA = 32'h0;
  logic HREADYOUT;
  logic [31:0] HRDATA;
  logic cs_n, rd_n, wr_n, DIVIDED_CLOCK_OUT, wide = 1'b0;
  logic [15:0] HOST_DATA_OUT, HOST_DATA_OE, lines;
  logic [4:0] COUNT_ENABLE_IN = 5'h0, COUNT_SOURCE_IN = 5'h0, WAVE_OUT, WAVE_OE;
  logic [4:0] gate_off = 5'h0;
  int miscompares = 0;
  int cmp_count = 0;
  always #25 REF_CLK = ~REF_CLK;
  mct_timer mct_timer_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(), .HOST_CS_N(cs_n), .HOST_RD_N(rd_n),
    .HOST_WR_N(wr_n), .HOST_DATA_IN(lines), .HOST_DATA_OUT(HOST_DATA_OUT),
    .HOST_DATA_OE(HOST_DATA_OE), .COUNT_ENABLE_IN(COUNT_ENABLE_IN),
    .COUNT_SOURCE_IN(COUNT_SOURCE_IN), .WAVE_OUT(WAVE_OUT), .WAVE_OE(WAVE_OE),
    .DIVIDED_CLOCK_OUT(DIVIDED_CLOCK_OUT));
  mct_host_model mct_host_model_i (.clk(REF_CLK), .dev_out(HOST_DATA_OUT),
    .dev_oe(HOST_DATA_OE), .wide(wide), .gate_off(gate_off), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .lines(lines));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_cnt(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      miscompares++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cnt
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : cyc
  function automatic logic [7:0] at(input logic [7:0] base, input int k);
    return base + 8'(k * 4);
  endfunction : at
  task automatic ahb(input logic w, input logic [7:0] a, input logic [15:0] wd,
                     output logic [31:0] rd);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= {16'h0, wd};
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 16'h0, x);
    chk_val(x, {16'h0, e});
  endtask : rd_chk
  // Counts high samples of a waveform line, or of the divided clock for sel 5.
  task automatic count_high(input int s, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge REF_CLK);
      if (((s == 5) ? DIVIDED_CLOCK_OUT : WAVE_OUT[s]) === 1'b1) c++;
    end
  endtask : count_high
  task automatic moving(input int k, input logic e);
    logic [31:0] a, b;
    ahb(1'b0, at(8'h50, k), 16'h0, a);
    cyc(8);
    ahb(1'b0, at(8'h50, k), 16'h0, b);
    chk_val({31'h0, a !== b}, {31'h0, e});
  endtask : moving
  task automatic set_pin(input logic e, input int k, input logic v);
    if (e) COUNT_ENABLE_IN[k] <= v;
    else COUNT_SOURCE_IN[k] <= v;
  endtask : set_pin
  task automatic pulses(input logic e, input int k, input int n);
    repeat (n) begin
      set_pin(e, k, 1'b1);
      cyc(3);
      set_pin(e, k, 1'b0);
      cyc(3);
    end
  endtask : pulses
  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    miscompares++;
    give_verdict;
  end
  initial begin
    logic [15:0] d, oe;
    logic v;
    int c;
    repeat (6) @(posedge REF_CLK);
    RST_N <= 1'b1;
    count_high(5, 32, c);
    chk_cnt(c, 16);
    rd_chk(8'h00, 16'h0000);
    rd_chk(8'hfc, 16'h0000);
    for (int n = 1; n <= 16; n++) begin
      wr(8'h00, 16'(n % 16));
      cyc(20);
      count_high(5, 4 * n, c);
      chk_cnt(c, 4 * ((n + 1) / 2));
    end
    wr(8'h00, 16'h0100);
    cyc(2);
    count_high(5, 32, c);
    chk_cnt(c, 0);
    for (int e = 0; e < 2; e++) begin
      wr(8'h00, e ? 16'h0062 : 16'h0012);
      cyc(6);
      v = DIVIDED_CLOCK_OUT;
      pulses(e[0], 0, 1);
      cyc(4);
      chk_val({31'h0, DIVIDED_CLOCK_OUT}, {31'h0, ~v});
    end
    wr(8'h00, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      wr(at(8'h30, k), 16'h0003);
      wr(at(8'h10, k), 16'hc000);
      cyc(10);
      chk_val({31'h0, WAVE_OE[k]}, 32'h1);
      count_high(k, 30, c);
      chk_cnt(c, 10);
      wr(at(8'h10, k), 16'hc800);
      cyc(10);
      count_high(k, 30, c);
      chk_cnt(c, 20);
      wr(at(8'h10, k), 16'hd000);
      cyc(10);
      count_high(k, 30, c);
      chk_cnt(c, 15);
      wr(at(8'h10, k), 16'h0000);
      for (int e = 0; e < 2; e++) begin
        for (int f = 0; f < 2; f++) begin
          wr(at(8'h30, k), 16'h0005);
          wr(at(8'h10, k), 16'(16'h8000 | (f << 4) | (e ? 6 + k : 1 + k)));
          pulses(e[0], k, 3);
          set_pin(e[0], k, 1'b1);
          cyc(6);
          rd_chk(at(8'h50, k), f ? 16'h0002 : 16'h0001);
          wr(at(8'h10, k), 16'h0000);
          set_pin(e[0], k, 1'b0);
          cyc(6);
        end
      end
    end
    for (int k = 0; k < 3; k++) begin
      wr(at(8'h30, k), 16'h1000);
      wr(at(8'h10, k), 16'h8200);
    end
    cyc(4);
    for (int k = 0; k < 3; k++) moving(k, 1'b0);
    COUNT_ENABLE_IN[0] <= 1'b1;
    cyc(4);
    for (int k = 0; k < 3; k++) moving(k, 1'b1);
    wr(8'h10, 16'h8300);
    moving(0, 1'b0);
    wr(8'h14, 16'h8000);
    COUNT_ENABLE_IN[0] <= 1'b0;
    cyc(4);
    moving(1, 1'b1);
    moving(2, 1'b0);
    gate_off <= 5'b00100;
    cyc(4);
    moving(2, 1'b1);
    gate_off <= 5'b00000;
    COUNT_ENABLE_IN[0] <= 1'b1;
    wr(8'h18, 16'h8600);
    moving(2, 1'b1);
    gate_off <= 5'b00100;
    cyc(4);
    moving(2, 1'b0);
    gate_off <= 5'b00000;
    COUNT_ENABLE_IN[0] <= 1'b0;
    wr(8'h18, 16'h8400);
    moving(2, 1'b0);
    pulses(1'b1, 0, 1);
    moving(2, 1'b1);
    for (int k = 0; k < 3; k++) wr(at(8'h10, k), 16'h0000);
    for (int k = 0; k < 2; k++) begin
      wr(at(8'h30, k), 16'h0007);
      wr(at(8'h70, k), 16'h0007);
      wr(at(8'h10, k), 16'h6000);
      cyc(3);
      chk_val({31'h0, WAVE_OUT[k]}, 32'h1);
      wr(at(8'h70, k), 16'h0006);
      cyc(3);
      chk_val({31'h0, WAVE_OUT[k]}, 32'h0);
    end
    chk_val({16'h0, HOST_DATA_OE}, 32'h0);
    wr(8'h08, 16'h1234);
    mct_host_model_i.host_read(d, oe);
    chk_val({16'h0, oe}, 32'h00ff);
    chk_val({24'h0, d[7:0]}, 32'h34);
    mct_host_model_i.host_write(16'h5aa5);
    rd_chk(8'h04, 16'h00a5);
    wr(8'h00, 16'h0200);
    wide <= 1'b1;
    mct_host_model_i.host_write(16'h5aa5);
    rd_chk(8'h04, 16'h5aa5);
    mct_host_model_i.host_read(d, oe);
    chk_val({oe, d}, 32'hffff1234);
    cyc(2);
    chk_val({16'h0, HOST_DATA_OE}, 32'h0);
    give_verdict;
  end
endmodule : tb_top

// ==== verilog/mct_pin_sync.sv ====
// Two-stage synchroniser with edge detection for the counter input pins.
`timescale 1ns/1ns
module mct_pin_sync #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw pins
  input wire logic [W-1:0] pins,
  // Synchronised level and edges
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } mct_sync_t;

  mct_sync_t s_reg;
  mct_sync_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.s1 = pins;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Edges come from the second and third stages only.
  assign level = s_reg.s2;
  assign rise = s_reg.s2 & ~s_reg.s3;
  assign fall = ~s_reg.s2 & s_reg.s3;

endmodule : mct_pin_sync

// ==== verilog/mct_pkg.sv ====
// Types shared by the multi-counter timer files.
package mct_pkg;

  typedef enum logic [1:0] {
    MCT_GATE_OFF,
    MCT_GATE_LEVEL,
    MCT_GATE_EDGE,
    MCT_GATE_AUX
  } mct_gate_mode_t;

  typedef logic [1:0] mct_htrans_t;

endpackage : mct_pkg

// ==== verilog/mct_regs.svh ====
// Register offsets, field positions and constants of the multi-counter timer.
`ifndef MCT_REGS_SVH
`define MCT_REGS_SVH

`define MCT_OFF_SETUP 8'h00
`define MCT_OFF_HOST_IN 8'h04
`define MCT_OFF_HOST_OUT 8'h08
`define MCT_OFF_STATUS 8'h0c
`define MCT_OFF_MODE 8'h10
`define MCT_OFF_LOAD 8'h30
`define MCT_OFF_COUNT 8'h50
`define MCT_OFF_ALARM 8'h70
`define MCT_STRIDE_SH 2

`define MCT_SETUP_RST 16'h0000
`define MCT_SU_DIV_LSB 0
`define MCT_SU_DIV_MSB 3
`define MCT_SU_SRC_LSB 4
`define MCT_SU_SRC_MSB 7
`define MCT_SU_DIVIDED_CLOCK_PIN_OFF 8
`define MCT_SU_BUS16 9

`define MCT_MD_SRC_LSB 0
`define MCT_MD_SRC_MSB 3
`define MCT_MD_SRC_FALL 4
`define MCT_MD_GSEL_LSB 5
`define MCT_MD_GSEL_MSB 7
`define MCT_MD_GATE_LOW 8
`define MCT_MD_GM_LSB 9
`define MCT_MD_GM_MSB 10
`define MCT_MD_OUT_LOW 11
`define MCT_MD_TOGGLE 12
`define MCT_MD_ALARM_EN 13
`define MCT_MD_OUT_EN 14
`define MCT_MD_RUN 15

`define MCT_SEL_TAP 4'h0
`define MCT_SEL_SRC 4'h1
`define MCT_SEL_GATE 4'h6

`define MCT_UPPER_LINE_GATING_ENABLE_LINE 8
`define MCT_LOW_BYTE_MASK 16'h00ff
`define MCT_CNT_LAST 1

`endif

// ==== verilog/mct_timer.sv ====
// Multi-counter timing controller with AHB-Lite registers and host data port.
`timescale 1ns/1ns
`include "mct_regs.svh"
// How it works
// - Output divider ratio 1 to 16.
// - Divided clock switchable; off drives low.
// - Reset gives divide by 16 from tap.
// - Divider fields live in setup register.
// - Enable inputs gate counters, shared up to five.
// - Enable pins selectable as counting sources.
// - Enable polarity set per counter.
// - Level, edge, aux or no gating.
// - Eight-bit bus adds auxiliary enable qualifier.
// - Any source pin feeds any counter.
// - Source edge polarity set per counter.
// - Each counter drives three-state waveform line.
// - Waveform polarity set per counter.
// - Terminal state detected before reload.
// - Counters one, two: alarm compare output.
// - Sixteen data lines, high means one.
// - Bus resets eight bits wide, low lines.
// - Upper lines never driven in eight-bit mode.
// - Low upper line disables that counter's level or edge gating in eight-bit mode.
// - Lines input on write, driven on read.
module mct_timer #(
  parameter int NUM_CNT = 5,
  parameter int CNT_W = 16,
  parameter int DIV_W = 4
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire mct_pkg::mct_htrans_t HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // Host data port
  input wire logic HOST_CS_N,
  input wire logic HOST_RD_N,
  input wire logic HOST_WR_N,
  input wire logic [15:0] HOST_DATA_IN,
  output logic [15:0] HOST_DATA_OUT,
  output logic [15:0] HOST_DATA_OE,
  // Counter pins
  input wire logic [NUM_CNT-1:0] COUNT_ENABLE_IN,
  input wire logic [NUM_CNT-1:0] COUNT_SOURCE_IN,
  output logic [NUM_CNT-1:0] WAVE_OUT,
  output logic [NUM_CNT-1:0] WAVE_OE,
  output logic DIVIDED_CLOCK_OUT
);
  import mct_pkg::*;

  localparam int ALARM_N = 2;
  localparam int HOST_W = 16;

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [15:0] setup;
    logic [NUM_CNT-1:0][15:0] mode;
    logic [NUM_CNT-1:0][CNT_W-1:0] load;
    logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
    logic [ALARM_N-1:0][CNT_W-1:0] alarm;
    logic [NUM_CNT-1:0] armed;
    logic [NUM_CNT-1:0] tc;
    logic [NUM_CNT-1:0] tgl;
    logic [NUM_CNT-1:0] wave;
    logic [DIV_W-1:0] fdiv;
    logic divided_clock_pin;
    logic [HOST_W-1:0] host_wr;
    logic [HOST_W-1:0] host_rd;
  } mct_state_t;

  mct_state_t s_reg;
  mct_state_t s_next;

  logic [2*NUM_CNT-1:0] sync_lvl;
  logic [2*NUM_CNT-1:0] sync_rise;
  logic [2*NUM_CNT-1:0] sync_fall;
  logic [NUM_CNT-1:0] gate_lvl;
  logic [NUM_CNT-1:0] gate_rise;
  logic [NUM_CNT-1:0] gate_fall;
  logic [NUM_CNT-1:0] src_rise;
  logic [NUM_CNT-1:0] src_fall;
  logic [NUM_CNT-1:0] allow_v;
  logic [NUM_CNT-1:0] evt_v;
  logic [NUM_CNT-1:0] ungated_v;
  logic bus8;
  logic ahb_go;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic pick_bit(input logic [NUM_CNT-1:0] v,
                                    input logic [3:0] idx);
    pick_bit = 1'b0;
    for (int k = 0; k < NUM_CNT; k++) begin
      if (idx == 4'(k)) begin
        pick_bit = v[k];
      end
    end
  endfunction : pick_bit

  // Tap code counts every clock; other codes pick a source or enable edge.
  function automatic logic pick_src(input logic [3:0] code,
                                    input logic [NUM_CNT-1:0] s_edge,
                                    input logic [NUM_CNT-1:0] g_edge);
    if (code == `MCT_SEL_TAP) begin
      pick_src = 1'b1;
    end else if (code >= `MCT_SEL_GATE) begin
      pick_src = pick_bit(g_edge, code - `MCT_SEL_GATE);
    end else begin
      pick_src = pick_bit(s_edge, code - `MCT_SEL_SRC);
    end
  endfunction : pick_src

  function automatic logic win_hit(input logic [7:0] a, input logic [7:0] base,
                                   input int n);
    win_hit = (a >= base) && ((a - base) < 8'(n << `MCT_STRIDE_SH));
  endfunction : win_hit

  function automatic logic [2:0] win_idx(input logic [7:0] a,
                                         input logic [7:0] base);
    win_idx = 3'((a - base) >> `MCT_STRIDE_SH);
  endfunction : win_idx

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  mct_pin_sync #(
    .W(2 * NUM_CNT)
  ) u_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .pins({COUNT_SOURCE_IN, COUNT_ENABLE_IN}),
    .level(sync_lvl),
    .rise(sync_rise),
    .fall(sync_fall)
  );

  assign gate_lvl = sync_lvl[NUM_CNT-1:0];
  assign gate_rise = sync_rise[NUM_CNT-1:0];
  assign gate_fall = sync_fall[NUM_CNT-1:0];
  assign src_rise = sync_rise[2*NUM_CNT-1:NUM_CNT];
  assign src_fall = sync_fall[2*NUM_CNT-1:NUM_CNT];

  assign bus8 = ~s_reg.setup[`MCT_SU_BUS16];
  assign ahb_go = HSEL & HTRANS[1] & HREADY;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic [15:0] md;
    logic [3:0] gsel;
    logic g;
    logic ge;
    logic evt;
    logic allow;
    logic tc;
    logic raw;
    logic [CNT_W-1:0] nc;
    mct_gate_mode_t gm;
    logic [DIV_W:0] ratio;
    logic [DIV_W-1:0] fn;
    logic fevt;
    logic [7:0] a;
    logic [31:0] rd;
    md = '0;
    gsel = '0;
    g = 1'b0;
    ge = 1'b0;
    evt = 1'b0;
    allow = 1'b0;
    tc = 1'b0;
    raw = 1'b0;
    nc = '0;
    gm = MCT_GATE_OFF;
    ratio = '0;
    fn = '0;
    fevt = 1'b0;
    a = '0;
    rd = '0;
    s_next = s_reg;
    allow_v = '0;
    evt_v = '0;
    ungated_v = '0;
    WAVE_OE = '0;

    for (int i = 0; i < NUM_CNT; i++) begin
      md = s_reg.mode[i];
      gm = mct_gate_mode_t'(md[`MCT_MD_GM_MSB:`MCT_MD_GM_LSB]);
      gsel = {1'b0, md[`MCT_MD_GSEL_MSB:`MCT_MD_GSEL_LSB]};
      g = pick_bit(gate_lvl, gsel) ^ md[`MCT_MD_GATE_LOW];
      ge = pick_bit(md[`MCT_MD_GATE_LOW] ? gate_fall : gate_rise, gsel);
      evt = pick_src(md[`MCT_MD_SRC_MSB:`MCT_MD_SRC_LSB],
                     md[`MCT_MD_SRC_FALL] ? src_fall : src_rise,
                     md[`MCT_MD_SRC_FALL] ? gate_fall : gate_rise);
      ungated_v[i] = bus8 && !HOST_DATA_IN[`MCT_UPPER_LINE_GATING_ENABLE_LINE + i];
      case (gm)
        MCT_GATE_LEVEL: begin
          allow = g | ungated_v[i];
        end
        MCT_GATE_EDGE: begin
          allow = s_reg.armed[i] | ungated_v[i];
        end
        MCT_GATE_AUX: begin
          allow = g & (~bus8 | HOST_DATA_IN[`MCT_UPPER_LINE_GATING_ENABLE_LINE + i]);
        end
        default: begin
          allow = 1'b1;
        end
      endcase
      allow = allow & md[`MCT_MD_RUN];
      tc = allow & evt & (s_reg.cnt[i] <= CNT_W'(`MCT_CNT_LAST));
      nc = s_reg.cnt[i];
      if (allow & evt) begin
        nc = tc ? s_reg.load[i] : s_reg.cnt[i] - 1'b1;
      end
      // A start edge in the terminal cycle re-arms the counter.
      if (tc || !md[`MCT_MD_RUN]) begin
        s_next.armed[i] = 1'b0;
      end
      if (gm == MCT_GATE_EDGE && md[`MCT_MD_RUN] && ge) begin
        s_next.armed[i] = 1'b1;
      end
      s_next.cnt[i] = nc;
      s_next.tc[i] = tc;
      if (tc) begin
        s_next.tgl[i] = ~s_reg.tgl[i];
      end
      raw = md[`MCT_MD_TOGGLE] ? s_next.tgl[i] : tc;
      if (i < ALARM_N && md[`MCT_MD_ALARM_EN]) begin
        raw = (nc == s_reg.alarm[i % ALARM_N]);
      end
      s_next.wave[i] = raw ^ md[`MCT_MD_OUT_LOW];
      WAVE_OE[i] = md[`MCT_MD_OUT_EN];
      allow_v[i] = allow;
      evt_v[i] = evt;
    end

    // Divided clock output; a zero ratio field means sixteen.
    fevt = pick_src(s_reg.setup[`MCT_SU_SRC_MSB:`MCT_SU_SRC_LSB],
                    src_rise, gate_rise);
    ratio = {(s_reg.setup[`MCT_SU_DIV_MSB:`MCT_SU_DIV_LSB] == '0),
             s_reg.setup[`MCT_SU_DIV_MSB:`MCT_SU_DIV_LSB]};
    fn = s_reg.fdiv;
    if (fevt) begin
      fn = (s_reg.fdiv >= DIV_W'(ratio - 1'b1)) ? '0 : s_reg.fdiv + 1'b1;
    end
    s_next.fdiv = fn;
    s_next.divided_clock_pin = ~s_reg.setup[`MCT_SU_DIVIDED_CLOCK_PIN_OFF] & ({1'b0, fn} < (ratio >> 1) |
                  ({1'b0, fn} == (ratio >> 1) & ratio[0]));

    // Host data port writes; only the low byte is taken in eight-bit mode.
    if (!HOST_CS_N && !HOST_WR_N) begin
      s_next.host_wr = bus8 ? (HOST_DATA_IN & `MCT_LOW_BYTE_MASK)
                            : HOST_DATA_IN;
    end

    // Register read mux, sampled in the address phase.
    a = HADDR[7:0];
    if (a == `MCT_OFF_SETUP) begin
      rd = 32'(s_reg.setup);
    end else if (a == `MCT_OFF_HOST_IN) begin
      rd = 32'(s_reg.host_wr);
    end else if (a == `MCT_OFF_HOST_OUT) begin
      rd = 32'(s_reg.host_rd);
    end else if (a == `MCT_OFF_STATUS) begin
      rd = 32'(s_reg.wave);
    end else if (win_hit(a, `MCT_OFF_MODE, NUM_CNT)) begin
      rd = 32'(s_reg.mode[win_idx(a, `MCT_OFF_MODE)]);
    end else if (win_hit(a, `MCT_OFF_LOAD, NUM_CNT)) begin
      rd = 32'(s_reg.load[win_idx(a, `MCT_OFF_LOAD)]);
    end else if (win_hit(a, `MCT_OFF_COUNT, NUM_CNT)) begin
      rd = 32'(s_reg.cnt[win_idx(a, `MCT_OFF_COUNT)]);
    end else if (win_hit(a, `MCT_OFF_ALARM, ALARM_N)) begin
      rd = 32'(s_reg.alarm[win_idx(a, `MCT_OFF_ALARM) % ALARM_N]);
    end

    s_next.wr_pend = 1'b0;
    if (ahb_go) begin
      if (HWRITE) begin
        s_next.wr_pend = 1'b1;
        s_next.wr_addr = a;
      end else begin
        s_next.rdata = rd;
      end
    end

    // Register writes in the data phase take priority over counting.
    if (s_reg.wr_pend) begin
      a = s_reg.wr_addr;
      if (a == `MCT_OFF_SETUP) begin
        s_next.setup = HWDATA[15:0];
      end else if (a == `MCT_OFF_HOST_OUT) begin
        s_next.host_rd = HWDATA[15:0];
      end else if (win_hit(a, `MCT_OFF_MODE, NUM_CNT)) begin
        s_next.mode[win_idx(a, `MCT_OFF_MODE)] = HWDATA[15:0];
      end else if (win_hit(a, `MCT_OFF_LOAD, NUM_CNT)) begin
        s_next.load[win_idx(a, `MCT_OFF_LOAD)] = HWDATA[CNT_W-1:0];
        if (!s_reg.mode[win_idx(a, `MCT_OFF_LOAD)][`MCT_MD_RUN]) begin
          s_next.cnt[win_idx(a, `MCT_OFF_LOAD)] = HWDATA[CNT_W-1:0];
        end
      end else if (win_hit(a, `MCT_OFF_ALARM, ALARM_N)) begin
        s_next.alarm[win_idx(a, `MCT_OFF_ALARM) % ALARM_N] = HWDATA[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg <= '0;
      // Divider starts at its top so the first high phase after reset is full.
      s_reg.fdiv <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = s_reg.rdata;
  assign WAVE_OUT = s_reg.wave;
  assign DIVIDED_CLOCK_OUT = s_reg.divided_clock_pin;
  assign HOST_DATA_OUT = s_reg.host_rd;
  assign HOST_DATA_OE = (!HOST_CS_N && !HOST_RD_N) ?
                        (bus8 ? `MCT_LOW_BYTE_MASK : '1) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence divided_clock_pin_high8;
    DIVIDED_CLOCK_OUT [*8];
  endsequence

  sequence divided_clock_pin_low8;
    !DIVIDED_CLOCK_OUT [*8];
  endsequence

  chk_divided_clock_pin_off_low: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    s_reg.setup[`MCT_SU_DIVIDED_CLOCK_PIN_OFF] |=> !DIVIDED_CLOCK_OUT)
    else $error("divided clock high while switched off");

  chk_divided_clock_pin_div16: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    ($rose(RST_N) && s_reg.setup == `MCT_SETUP_RST)
    |-> ##1 divided_clock_pin_high8 ##1 divided_clock_pin_low8)
    else $error("reset divider is not a divide by sixteen");

  chk_upper_quiet: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    bus8 |-> HOST_DATA_OE[15:8] == '0)
    else $error("upper data lines driven in eight-bit mode");

  chk_read_drive: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (HOST_CS_N || HOST_RD_N) |-> HOST_DATA_OE == '0)
    else $error("data lines driven without a selected read");

  chk_low_byte_take: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (!HOST_CS_N && !HOST_WR_N && bus8) |=> s_reg.host_wr[15:8] == '0)
    else $error("upper byte captured in eight-bit mode");

  chk_tc_reload: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (s_reg.tc[0] && !$past(s_reg.wr_pend)) |-> s_reg.cnt[0] == $past(s_reg.load[0]))
    else $error("terminal count did not reload");

  chk_count_step: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (allow_v[0] && evt_v[0] && s_reg.cnt[0] > CNT_W'(`MCT_CNT_LAST) && !s_reg.wr_pend)
    |=> s_reg.cnt[0] == $past(s_reg.cnt[0]) - 1'b1)
    else $error("counter did not step down on a source event");

  chk_gate_hold: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (!allow_v[0] && !s_reg.wr_pend) |=> $stable(s_reg.cnt[0]))
    else $error("counter moved while gated off");

  chk_upper_line_gating_enable_free: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (ungated_v[2] && s_reg.mode[2][`MCT_MD_RUN] &&
     s_reg.mode[2][`MCT_MD_GM_MSB:`MCT_MD_GM_LSB] == 2'(MCT_GATE_LEVEL))
    |-> allow_v[2])
    else $error("low upper line did not disable gating");

  chk_alarm_match: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (s_reg.mode[0][`MCT_MD_ALARM_EN] && !s_reg.mode[0][`MCT_MD_OUT_LOW])
    |=> WAVE_OUT[0] == (s_reg.cnt[0] == $past(s_reg.alarm[0])))
    else $error("alarm compare output wrong");

endmodule : mct_timer
